// ### rtl/mrtc_top.sv
// MIDI clock sources, real-time queues and distributor
`timescale 1ns/1ps
`include "mrtc_map.svh"
// What this block does
// - Sync detector uses demodulator when input select zero and pin to receiver high
// - Sync rising edge makes clock event
// - Demodulator edge means low to high tone
// - Rate error forces demodulator output high
// - Timer counts 14-bit by ref clock divide
// - Timer step at most every sixteen clocks
// - Timer reload on a step at count one (or zero) makes clock event
// - Detector sees error-free F8 and F9..FD
// - Receive queue holds four ordered entries
// - Clock byte enters from selected source
// - Enabled detector enqueues F9..FD bytes
// - Full receive queue drops new entries
// - Read peeks oldest; advance removes it
// - Oldest clock byte auto-removed, pulses distributor when host clock not selected
// - Clock and message detect interrupts on head
// - Start, stop, continue drive counter actions
// - Distributor clock from queue or host
// - Other messages only to designated blocks
// - Transmit queue four bytes, drained when enabled
// - Enables gate clock and sense into queue
// - Reload value takes effect on high write
// - Immediate load reloads within 32 clocks
// - Empty queue reads as zero
module mrtc_top (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	// Configuration
	input  wire mrtc_pkg::mrtc_cfg_s    cfg,
	input  wire logic                   rxPinToReceiver,
	// Timer reload halves
	input  wire logic                   reloadLowWrite,
	input  wire logic                   reloadHighWrite,
	input  wire logic [7:0]             reloadData,
	// Host message request and queue advance
	input  wire mrtc_pkg::mrtc_hostmsg_s hostMsg,
	input  wire logic                   rxQueueAdvance,
	// Pins from outside domain
	input  wire logic                   demodOut,
	input  wire logic                   rateError,
	input  wire logic                   timerRefClock,
	// Receiver bytes
	input  wire logic                   rxByteValid,
	input  wire mrtc_pkg::mrtc_byte_t   rxByte,
	input  wire logic                   rxParityErr,
	input  wire logic                   rxFrameErr,
	// Idle detector and transmitter
	input  wire logic                   idleSense,
	input  wire logic                   txEnable,
	input  wire logic                   txTake,
	// Outputs
	output logic [7:0]                  rxQueueData,
	output logic                        clkDetectIrq,
	output logic                        msgDetectIrq,
	output logic                        txValid,
	output mrtc_pkg::mrtc_byte_t        txByte,
	output mrtc_pkg::mrtc_fan_s         fan
);
	import mrtc_pkg::*;

	typedef struct packed {
		logic [1:0]  demodSync;
		logic [1:0]  refSync;
		logic        demodPrev;
		logic        refPrev;
		logic [3:0]  preCnt;
		logic        preTick;
		logic [4:0]  gapCnt;
		logic [13:0] count;
		logic [13:0] reload;
		logic [7:0]  lowHold;
		logic        loadPend;
		logic [31:0] rxMem;
		logic [2:0]  rxCnt;
		logic [31:0] txMem;
		logic [2:0]  txCnt;
		logic [7:0]  rxData;
		logic        clkIrq;
		logic        msgIrq;
		logic        txValid;
		logic [7:0]  txByte;
		mrtc_fan_s   fan;
	} mrtc_state_s;

	mrtc_state_s s_q;
	mrtc_state_s s_d;

	logic        demodIn;
	logic        syncEvt;
	logic        timerEvt;
	logic        detClk;
	logic        detMsg;
	logic        isRt;
	logic        clkEvt;
	mrtc_byte_t  head;
	logic        headClk;
	logic        rxPop;
	logic        distClk;
	logic        distMsg;
	mrtc_byte_t  distByte;
	logic        txPushA;
	logic        txPushB;
	logic [2:0]  rxN;
	logic [2:0]  txN;
	logic [31:0] rxMemN;
	logic [31:0] txMemN;
	logic        hostClk;
	logic        hostCodeOk;
	mrtc_dist_s  pickTx;
	mrtc_dist_s  pickSync;
	mrtc_dist_s  pickClick;
	mrtc_dist_s  pickPlay;
	mrtc_dist_s  pickRec;

	// Distributor taps, one per block
	// Transmit queue
	mrtc_dist_port #(
		.DEST(`MRTC_DEST_TX)
	) distTx (
		.clkPulse (distClk),
		.msgPulse (distMsg),
		.msgByte  (distByte),
		.destMask (hostMsg.destMask),
		.pick     (pickTx)
	);

	// Sync controller
	mrtc_dist_port #(
		.DEST(`MRTC_DEST_SYNC)
	) distSync (
		.clkPulse (distClk),
		.msgPulse (distMsg),
		.msgByte  (distByte),
		.destMask (hostMsg.destMask),
		.pick     (pickSync)
	);

	// Click counter
	mrtc_dist_port #(
		.DEST(`MRTC_DEST_CLICK)
	) distClick (
		.clkPulse (distClk),
		.msgPulse (distMsg),
		.msgByte  (distByte),
		.destMask (hostMsg.destMask),
		.pick     (pickClick)
	);

	// Playback counter
	mrtc_dist_port #(
		.DEST(`MRTC_DEST_PLAY)
	) distPlay (
		.clkPulse (distClk),
		.msgPulse (distMsg),
		.msgByte  (distByte),
		.destMask (hostMsg.destMask),
		.pick     (pickPlay)
	);

	// Recording counter
	mrtc_dist_port #(
		.DEST(`MRTC_DEST_REC)
	) distRec (
		.clkPulse (distClk),
		.msgPulse (distMsg),
		.msgByte  (distByte),
		.destMask (hostMsg.destMask),
		.pick     (pickRec)
	);

	always_comb begin
		s_d = s_q;
		// Synchronise pin-side inputs
		s_d.demodSync = {s_q.demodSync[0], demodOut | rateError};
		s_d.refSync   = {s_q.refSync[0], timerRefClock};
		s_d.demodPrev = s_q.demodSync[1];
		s_d.refPrev   = s_q.refSync[1];
		demodIn = s_q.demodSync[1] & ~cfg.rxInputSelect & rxPinToReceiver;
		syncEvt = demodIn & ~(s_q.demodPrev & ~cfg.rxInputSelect & rxPinToReceiver);

		// Prescaler on reference edges
		s_d.preTick = 1'b0;
		if (s_q.refSync[1] && !s_q.refPrev) begin
			if (s_q.preCnt >= (cfg.refFreqSelect ? `MRTC_PRE_DIV8 : `MRTC_PRE_DIV4)) begin
				s_d.preCnt = 4'h0;
				s_d.preTick = 1'b1;
			end else begin
				s_d.preCnt = s_q.preCnt + 4'h1;
			end
		end
		if (s_q.gapCnt != 5'h00) begin
			s_d.gapCnt = s_q.gapCnt - 5'h01;
		end

		// Reload value staged until high half
		if (reloadLowWrite) begin
			s_d.lowHold = reloadData;
		end
		if (reloadHighWrite) begin
			s_d.reload = {reloadData[5:0], s_q.lowHold};
			if (reloadData[7]) begin
				s_d.loadPend = 1'b1;
			end
		end

		timerEvt = 1'b0;
		if (s_q.loadPend) begin
			s_d.count = s_q.reload;
			s_d.loadPend = 1'b0;
			timerEvt = 1'b1;
		end else if ((s_q.preTick || s_d.preTick) && s_q.gapCnt == 5'h00) begin
			s_d.preTick = 1'b0;
			s_d.gapCnt = `MRTC_MIN_GAP - 5'h01;
			if (s_q.count <= 14'h0001) begin
				s_d.count = s_q.reload;
				timerEvt = 1'b1;
			end else begin
				s_d.count = s_q.count - 14'h0001;
			end
		end else if (s_q.preTick) begin
			s_d.preTick = 1'b1;
		end

		// Message detector
		isRt   = rxByte >= `MRTC_RT_LO && rxByte <= `MRTC_RT_HI;
		detClk = rxByteValid && !rxParityErr && !rxFrameErr && rxByte == `MRTC_CLK_MSG;
		detMsg = rxByteValid && !rxParityErr && !rxFrameErr && isRt && cfg.detectEnable;

		case (cfg.clkSrcSel)
			`MRTC_SRC_DETECT: clkEvt = detClk;
			`MRTC_SRC_SYNC:   clkEvt = syncEvt;
			`MRTC_SRC_TIMER:  clkEvt = timerEvt;
			default:          clkEvt = 1'b0;
		endcase

		// Receive queue: head at low byte
		head    = s_q.rxMem[7:0];
		headClk = s_q.rxCnt != 3'h0 && head == `MRTC_CLK_MSG;
		rxPop   = headClk | (rxQueueAdvance && s_q.rxCnt != 3'h0);
		rxMemN  = rxPop ? {8'h00, s_q.rxMem[31:8]} : s_q.rxMem;
		rxN     = rxPop ? s_q.rxCnt - 3'h1 : s_q.rxCnt;
		// Clock first, then a detected byte of the same cycle
		if (clkEvt && rxN < `MRTC_QDEPTH) begin
			rxMemN[rxN*8 +: 8] = `MRTC_CLK_MSG;
			rxN = rxN + 3'h1;
		end
		if (detMsg && rxN < `MRTC_QDEPTH) begin
			rxMemN[rxN*8 +: 8] = rxByte;
			rxN = rxN + 3'h1;
		end
		s_d.rxMem = rxMemN;
		s_d.rxCnt = rxN;
		s_d.rxData = rxN == 3'h0 ? `MRTC_EMPTY_DATA : rxMemN[7:0];
		s_d.clkIrq = rxN != 3'h0 && rxMemN[7:0] == `MRTC_CLK_MSG;
		s_d.msgIrq = rxN != 3'h0 && rxMemN[7:0] >= `MRTC_RT_LO && rxMemN[7:0] <= `MRTC_RT_HI;

		// Distributor
		hostClk    = hostMsg.write && hostMsg.msgCode == 3'h0;
		distClk    = cfg.distHostClk ? hostClk : headClk;
		// Codes above four are reserved and dropped
		hostCodeOk = hostMsg.msgCode <= `MRTC_HOST_CODE_MAX;
		distMsg    = hostMsg.write && hostMsg.msgCode != 3'h0 && hostCodeOk;
		distByte   = {5'h1F, hostMsg.msgCode};
		s_d.fan.tx    = pickTx;
		s_d.fan.sync  = pickSync;
		s_d.fan.click = pickClick;
		s_d.fan.play  = pickPlay;
		s_d.fan.rec   = pickRec;

		// Transmit queue, distributor entry then sense
		txPushA = s_q.fan.tx.msgValid || (s_q.fan.tx.clkOut && cfg.txClkEnable);
		txPushB = idleSense && cfg.txSenseEnable;
		txMemN  = s_q.txMem;
		txN     = s_q.txCnt;
		if (s_q.txValid && txTake) begin
			txMemN = {8'h00, s_q.txMem[31:8]};
			txN = txN - 3'h1;
		end
		if (txPushA && txN < `MRTC_QDEPTH) begin
			txMemN[txN*8 +: 8] = s_q.fan.tx.msgValid ? s_q.fan.tx.msg : `MRTC_CLK_MSG;
			txN = txN + 3'h1;
		end
		if (txPushB && txN < `MRTC_QDEPTH) begin
			txMemN[txN*8 +: 8] = `MRTC_SENSE_MSG;
			txN = txN + 3'h1;
		end
		s_d.txMem = txMemN;
		s_d.txCnt = txN;
		s_d.txValid = txEnable && txN != 3'h0 && !(s_q.txValid && txTake);
		s_d.txByte = txMemN[7:0];
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rxQueueData  = s_q.rxData;
	assign clkDetectIrq = s_q.clkIrq;
	assign msgDetectIrq = s_q.msgIrq;
	assign txValid      = s_q.txValid;
	assign txByte       = s_q.txByte;
	assign fan          = s_q.fan;
endmodule

// One distributor output: clock always, messages only when designated
module mrtc_dist_port #(
	parameter int unsigned DEST = 0
) (
	// Distributor request
	input  wire logic                 clkPulse,
	input  wire logic                 msgPulse,
	input  wire mrtc_pkg::mrtc_byte_t msgByte,
	input  wire logic [4:0]           destMask,
	// Pulses for this block
	output mrtc_pkg::mrtc_dist_s      pick
);
	import mrtc_pkg::*;

	logic sel;

	always_comb begin
		pick = '0;
		pick.clkOut = clkPulse;
		sel = destMask[DEST];
		if (msgPulse && sel) begin
			pick.msg      = msgByte;
			pick.msgValid = 1'b1;
			pick.startOut = (msgByte == `MRTC_START_MSG);
			pick.contOut  = (msgByte == `MRTC_CONT_MSG);
			pick.stopOut  = (msgByte == `MRTC_STOP_MSG);
		end
	end
endmodule

// ### inc/mrtc_map.svh
// Constants for the MIDI real-time clock controller
`ifndef MRTC_MAP_SVH
`define MRTC_MAP_SVH
`define MRTC_CLK_MSG         8'hF8
`define MRTC_RT_LO           8'hF9
`define MRTC_RT_HI           8'hFD
`define MRTC_SENSE_MSG       8'hFE
`define MRTC_START_MSG       8'hFA
`define MRTC_CONT_MSG        8'hFB
`define MRTC_STOP_MSG        8'hFC
`define MRTC_EMPTY_DATA      8'h00
`define MRTC_QDEPTH          3'h4
`define MRTC_SYS_PERIOD_NS   20
`define MRTC_CLK_HZ          50000000
`define MRTC_MIN_GAP         5'h10
`define MRTC_LOAD_LIMIT_SYSTEM_CLOCK_PERIOD 32
`define MRTC_PRE_DIV4        4'h3
`define MRTC_PRE_DIV8        4'h7
`define MRTC_SRC_DETECT      2'h3
`define MRTC_SRC_SYNC        2'h2
`define MRTC_SRC_TIMER       2'h1
`define MRTC_TIMER_RST       14'h0000
`define MRTC_DEST_TX         0
`define MRTC_DEST_SYNC       1
`define MRTC_DEST_CLICK      2
`define MRTC_DEST_PLAY       3
`define MRTC_DEST_REC        4
`define MRTC_HOST_CODE_MAX   3'h4
`endif

// ### inc/mrtc_pkg.sv
// Types for the MIDI real-time clock controller
package mrtc_pkg;
	typedef logic [7:0] mrtc_byte_t;
	typedef struct packed {
		logic       clkOut;
		logic       startOut;
		logic       stopOut;
		logic       contOut;
		mrtc_byte_t msg;
		logic       msgValid;
	} mrtc_dist_s;
	typedef struct packed {
		mrtc_dist_s tx;
		mrtc_dist_s sync;
		mrtc_dist_s click;
		mrtc_dist_s play;
		mrtc_dist_s rec;
	} mrtc_fan_s;
	typedef struct packed {
		logic [4:0] destMask;
		logic [2:0] msgCode;
		logic       write;
	} mrtc_hostmsg_s;
	typedef struct packed {
		logic [1:0] clkSrcSel;
		logic       distHostClk;
		logic       detectEnable;
		logic       txClkEnable;
		logic       txSenseEnable;
		logic       refFreqSelect;
		logic       rxInputSelect;
	} mrtc_cfg_s;
endpackage

// ### testbench/mrtc_top_asserts.sv
// Port checker for the clock controller
`timescale 1ns/1ps
`include "mrtc_map.svh"
module mrtc_top_asserts (
	// Watched inputs
	input wire logic			ref_clk,
	input wire logic			rst,
	input wire mrtc_pkg::mrtc_cfg_s		cfg,
	input wire mrtc_pkg::mrtc_hostmsg_s	hostMsg,
	input wire logic			reloadHighWrite,
	input wire logic [7:0]			reloadData,
	input wire logic			rxByteValid,
	input wire mrtc_pkg::mrtc_byte_t	rxByte,
	input wire logic			rxParityErr,
	input wire logic			rxFrameErr,
	// Watched outputs
	input wire logic [7:0]			rxQueueData,
	input wire logic			clkDetectIrq,
	input wire logic			msgDetectIrq,
	input wire mrtc_pkg::mrtc_fan_s		fan
);
	import mrtc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence goodRt;
		rxByteValid && !rxParityErr && !rxFrameErr && cfg.detectEnable && rxByte inside {[8'hF9:8'hFD]};
	endsequence
	sequence idleQ;
		rxQueueData == 8'h00 && cfg.clkSrcSel == 2'h0;
	endsequence
	a_clk_all_blocks: assert property (
		fan.sync.clkOut |-> fan.tx.clkOut && fan.click.clkOut && fan.play.clkOut && fan.rec.clkOut)
		else $error("clock missing on a block");
	a_head_clk_pulse: assert property (clkDetectIrq && !cfg.distHostClk |=> fan.click.clkOut)
		else $error("head clock not distributed");
	a_irq_head_code: assert property (
		(clkDetectIrq |-> rxQueueData == 8'hF8) and (msgDetectIrq |-> rxQueueData inside {[8'hF9:8'hFD]}))
		else $error("interrupt does not match head");
	a_err_dropped: assert property (idleQ and (rxByteValid && (rxParityErr || rxFrameErr)) |=> rxQueueData == 8'h00)
		else $error("errored byte queued");
	a_detect_push: assert property (goodRt and idleQ |=> rxQueueData == $past(rxByte) && msgDetectIrq)
		else $error("detected message not queued");
	a_detect_off: assert property (idleQ and (rxByteValid && !cfg.detectEnable) |=> rxQueueData == 8'h00)
		else $error("disabled detector queued");
	a_host_dest: assert property (
		fan.click.startOut || fan.click.stopOut || fan.click.contOut
		|-> $past(hostMsg.write) && $past(hostMsg.destMask[`MRTC_DEST_CLICK]))
		else $error("message to undesignated block");
	a_start_code: assert property (
		hostMsg.write && hostMsg.destMask[`MRTC_DEST_CLICK] && hostMsg.msgCode == 3'h2
		|=> fan.click.startOut && fan.click.msg == 8'hFA)
		else $error("start not delivered");
	a_load_event: assert property (
		reloadHighWrite && reloadData[7] && cfg.clkSrcSel == 2'h1 && rxQueueData == 8'h00 |-> ##[1:36] clkDetectIrq)
		else $error("immediate load gave no clock");
endmodule
bind mrtc_top mrtc_top_asserts assertChk (.*);

// ### testbench/mrtc_link_model.sv
// Stand-in for the serial transmitter side
`timescale 1ns/1ps
module mrtc_link_model (
	// Clock and pacing
	input wire logic			ref_clk,
	input wire logic			slow,
	// Transmit queue handshake
	input wire logic			txValid,
	input wire mrtc_pkg::mrtc_byte_t	txByte,
	output logic				txTake,
	output mrtc_pkg::mrtc_byte_t		lastTx
);
	import mrtc_pkg::*;
	logic [1:0]	waitCnt = 2'h0;
	initial txTake = 1'h0;
	// One byte per take, slowly when asked
	always @(negedge ref_clk) begin
		txTake <= 1'h0;
		if (txValid && !txTake) begin
			waitCnt <= waitCnt + 2'h1;
			if (!slow || waitCnt == 2'h3) begin
				txTake <= 1'h1;
				lastTx <= txByte;
			end
		end
	end
endmodule

// ### testbench/mrtc_top_tb.sv
// Self-checking bench for the clock controller
`timescale 1ns/1ps
`include "mrtc_map.svh"
module mrtc_top_tb;
	import mrtc_pkg::*;
	logic		ref_clk = 0, rst = 1, rxPinToReceiver = 1, reloadLowWrite = 0, reloadHighWrite = 0;
	logic		rxQueueAdvance = 0, demodOut = 0, rateError = 0, timerRefClock = 0, rxByteValid = 0;
	logic		rxParityErr = 0, rxFrameErr = 0, idleSense = 0, txEnable = 1, slow = 1;
	logic		txTake, txValid, clkDetectIrq, msgDetectIrq;
	logic [7:0]	reloadData = 0, rxQueueData, lastTx;
	mrtc_cfg_s	cfg = '0;
	mrtc_hostmsg_s	hostMsg = '0;
	mrtc_byte_t	rxByte = 0, txByte;
	mrtc_fan_s	fan;
	logic [3:0]	expQ[$];
	logic [31:0]	seed = 32'hF910;
	int		errors = 0, nCompared = 0, cyc = 0, t;
	wire [3:0]	clickEv = {fan.click.clkOut, fan.click.startOut, fan.click.stopOut, fan.click.contOut};
	mrtc_top dut (.*);
	mrtc_link_model link (.*);
	initial forever #10 ref_clk = ~ref_clk;
	always #100 timerRefClock = ~timerRefClock;
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (errors == 0 && nCompared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic rxSend(mrtc_byte_t b, logic [1:0] e);
		{rxByte, rxByteValid, rxFrameErr, rxParityErr} <= {b, 1'h1, e};
		tick(1);
		{rxByte, rxByteValid, rxFrameErr, rxParityErr} <= {~b, 3'h0};
		tick(1);
	endtask
	task automatic adv;
		rxQueueAdvance <= 1;
		tick(1);
		rxQueueAdvance <= 0;
		tick(3);
	endtask
	task automatic wrReload(logic hi, logic [7:0] d);
		{reloadHighWrite, reloadLowWrite, reloadData} <= {hi, !hi, d};
		tick(1);
		{reloadHighWrite, reloadLowWrite} <= 2'h0;
	endtask
	task automatic hmsg(logic [4:0] m, logic [2:0] c);
		hostMsg <= {m, c, 1'h1};
		tick(1);
		hostMsg.write <= 0;
		tick(16);
	endtask
	task automatic waitClk;
		for (t = 0; t < 600 && !clickEv[3]; t++)
			tick(1);
		tick(1);
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test;
		end
		if (|clickEv)
			chk({4'h0, clickEv}, expQ.size() > 0 ? {4'h0, expQ.pop_front()} : 8'hFF);
	end
	initial begin
		tick(4);
		rst <= 0;
		tick(2);
		rxSend(8'hF9, 2'h0);
		cfg.detectEnable <= 1;
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			rxSend(8'hF9 + seed[7:0] % 5, 2'h1 << seed[8]);
		end
		chk(rxQueueData, 8'h00);
		for (int i = 0; i < 6; i++)
			rxSend(8'hF9 + i[7:0], 2'h0);
		for (int i = 0; i < 5; i++) begin
			chk(rxQueueData, i < 4 ? 8'hF9 + i[7:0] : 8'h00);
			chk({msgDetectIrq, clkDetectIrq}, i < 4 ? 8'h2 : 8'h0);
			adv();
		end
		cfg.clkSrcSel <= 2'h3;
		rxSend(8'hF8, 2'h2);
		rxSend(8'hF9, 2'h0);
		rxSend(8'hF8, 2'h0);
		chk(rxQueueData, 8'hF9);
		expQ.push_back(4'h8);
		adv();
		chk(rxQueueData, 8'h00);
		cfg.clkSrcSel <= 2'h2;
		for (int i = 0; i < 8; i++) begin
			{rxPinToReceiver, cfg.rxInputSelect} <= i[1:0];
			tick(4);
			if (i[1:0] == 2'h2)
				expQ.push_back(4'h8);
			{rateError, demodOut} <= {i[2], !i[2]};
			tick(8);
			{rateError, demodOut} <= 2'h0;
			tick(8);
		end
		for (int s = 0; s < 2; s++) begin
			cfg.refFreqSelect <= s[0];
			repeat (5) expQ.push_back(4'h8);
			wrReload(0, 8'h03);
			tick(16);
			wrReload(1, 8'h80);
			cfg.clkSrcSel <= 2'h1;
			waitClk();
			waitClk();
			waitClk();
			chk(8'(t + 1), s ? 8'hF0 : 8'h78);
			wrReload(0, 8'h06);
			waitClk();
			waitClk();
			chk(8'(t + 1), s ? 8'hF0 : 8'h78);
		end
		cfg <= 8'h3C;
		for (int c = 2; c < 5; c++) begin
			expQ.push_back(c == 2 ? 4'h4 : c == 3 ? 4'h1 : 4'h2);
			hmsg(5'h1 << `MRTC_DEST_TX | 5'h1 << `MRTC_DEST_CLICK, c[2:0]);
			chk(lastTx, 8'hF8 + c[7:0]);
		end
		hmsg(5'h1 << `MRTC_DEST_TX, 3'h7);
		chk(lastTx, 8'hFC);
		slow <= 0;
		hmsg(5'h1 << `MRTC_DEST_SYNC, 3'h2);
		cfg.txClkEnable <= 0;
		expQ.push_back(4'h8);
		hmsg(5'h0, 3'h0);
		chk(lastTx, 8'hFC);
		cfg.txClkEnable <= 1;
		expQ.push_back(4'h8);
		hmsg(5'h0, 3'h0);
		chk(lastTx, 8'hF8);
		idleSense <= 1;
		tick(1);
		idleSense <= 0;
		tick(8);
		chk(lastTx, 8'hFE);
		txEnable <= 0;
		hmsg(5'h1 << `MRTC_DEST_TX, 3'h3);
		chk(lastTx, 8'hFE);
		chk({7'h0, txValid}, 8'h00);
		txEnable <= 1;
		tick(8);
		chk(lastTx, 8'hFB);
		tick(20);
		chk(8'(expQ.size()), 8'h00);
		end_of_test;
	end
endmodule
